// ### ep_status_ctrl.sv
`timescale 1ns/1ps
module ep_status_ctrl
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   ep_status_if.ctrl        bus,
   input  wire logic [3:0]  sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic [31:0]      sw_rdata
);
   import ep_status_pkg::*;

   logic [19:0] addr_ff;
   logic [31:0] wdata_ff;
   logic [31:0] rdata_ff;
   logic [31:0] sw_rdata_ff;
   logic        busy_ff;
   op_t         op_ff;

   // Command register: bit 0 issues a write, bit 1 issues a read.
   wire         cmd_go  = sw_wr && (sw_addr == HOFS_CMD) && !busy_ff;
   wire         cmd_rd  = cmd_go && sw_wdata[1];
   wire [31:0]  sw_sel  =
      (sw_addr == HOFS_ADDR)   ? {12'h000, addr_ff} :
      (sw_addr == HOFS_WDATA)  ? wdata_ff :
      (sw_addr == HOFS_RDATA)  ? rdata_ff :
      (sw_addr == HOFS_STATUS) ? {31'h00000000, busy_ff} :
      32'h00000000;

   // Device access sequencer; one outstanding access at a time.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         addr_ff  <= 20'h00000;
         wdata_ff <= 32'h00000000;
         rdata_ff <= 32'h00000000;
         busy_ff  <= 1'b0;
         op_ff    <= OP_IDLE;
      end else begin
         if (sw_wr && sw_addr == HOFS_ADDR) begin
            addr_ff <= sw_wdata[19:0];
         end
         if (sw_wr && sw_addr == HOFS_WDATA) begin
            wdata_ff <= sw_wdata;
         end
         op_ff <= cmd_go ? (cmd_rd ? OP_READ : (sw_wdata[0] ? OP_WRITE : OP_IDLE))
                         : OP_IDLE;
         if (cmd_rd) begin
            busy_ff <= 1'b1;
         end else if (bus.rvalid) begin
            busy_ff  <= 1'b0;
            rdata_ff <= bus.rdata;
         end
      end
   end

   // Software read port answers one cycle after the strobe.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sw_rdata_ff <= 32'h00000000;
      end else begin
         sw_rdata_ff <= sw_rd ? sw_sel : 32'h00000000;
      end
   end

   assign bus.op    = op_ff;
   assign bus.addr  = addr_ff;
   assign bus.wdata = wdata_ff;
   assign sw_rdata  = sw_rdata_ff;
endmodule

// ### ep_status_device.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// [R1] Endpoint 0 active flag always reads one.
// [R2] Two-bit packet size code; zero means 64.
// [R3] Software reads summary, then endpoint flags.
// [R4] Clearing a flag clears the summary bits.
// [R5] NAK flag set on NAK or ISO zero-length.
// [R6] Dropped-packet flag never raises an interrupt.
// [R7] FIFO-empty flag resets one, level-selectable threshold.
// [R8] NAK-effective set once NAK sampled; STALL wins.
// [R9] Flag IN token while FIFO empty.
// [R10] Flag timeout on last IN token.
// [R11] Bus error flag; failing address stays readable.
// [R12] Done flag only after both sides finish.
// [R13] Hardware sets flags; software writes one clears.
// [R14] Packet count decrements per packet read out.
// [R15] Transfer size decrements per packet written in.
// [R16] Software programs length before enable, reads after.
// [R17] DMA pointer word aligned, steps each transaction.
// [R18] Stored SETUP data overwritten after three back-to-back.
// [R19] Free space in words, resets to 0x0200.
// [R20] Enable cleared before done or disabled flags.
module ep_status_device
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   ep_status_if.device      bus,
   input  wire logic        nak_sent,
   input  wire logic        iso_zero_len,
   input  wire logic        iso_out_dropped,
   input  wire logic        babble_seen,
   input  wire logic        half_empty_level,
   input  wire logic        token_in,
   input  wire logic        token_timeout,
   input  wire logic        ahb_beat,
   input  wire logic        ahb_error,
   input  wire logic        pkt_to_fifo,
   input  wire logic [6:0]  pkt_bytes,
   input  wire logic        pkt_from_fifo,
   input  wire logic        setup_rcvd,
   input  wire logic        ahb_side_done,
   input  wire logic [15:0] fifo_free_in,
   output logic             ep_enabled,
   output logic             ep_nak,
   output logic             ep_stall,
   output logic [2:0]       setup_slot,
   output logic             ep_irq,
   output logic             all_ep_summary,
   output logic             core_in_summary
);
   import ep_status_pkg::*;

   logic        enable_ff;
   logic        nak_ff;
   logic        stall_ff;
   logic [1:0]  mps_ff;
   logic [13:0] ev_ff;
   logic [1:0]  pkt_ff;
   logic [6:0]  size_ff;
   logic [31:0] dma_ff;
   logic [15:0] free_ff;
   logic [1:0]  setup_run_ff;
   logic [2:0]  slot_ff;
   logic        disable_req_ff;
   logic [31:0] rdata_ff;
   logic        rvalid_ff;
   logic        irq_ff;

   // Register bus decode.
   wire         wr      = (bus.op == OP_WRITE);
   wire         rd      = (bus.op == OP_READ);
   wire         wr_ctl  = wr && (bus.addr == OFS_EP0_CONTROL);
   wire         wr_ev   = wr && (bus.addr == OFS_EP0_EVENTS);
   wire         wr_len  = wr && (bus.addr == OFS_EP0_LENGTH);
   wire         wr_dma  = wr && (bus.addr == OFS_EP0_DMA);
   // A clear-NAK write withdraws NAK, so it must not re-arm NAK-effective that cycle.
   wire         clr_nak_wr = wr_ctl && bus.wdata[CTL_CLR_NAK];

   // Transfer is finished when both packet count and size are used up and ahb_side_done is high.
   wire         xfer_end = enable_ff && (pkt_ff == 2'h0) && (size_ff == 7'h00)
                           && ahb_side_done;
   wire         user_dis = enable_ff && disable_req_ff;
   wire         fifo_empty = half_empty_level ? (free_ff >= FREE_HALF)
                                              : (free_ff == FREE_RESET);

   // Hardware set events; the set beats a simultaneous write-one clear.
   wire [13:0]  ev_set;
   assign ev_set[EV_NAK]         = nak_sent || iso_zero_len;          // [R5]
   assign ev_set[EV_BABBLE]      = babble_seen;
   assign ev_set[EV_DROP]        = iso_out_dropped;                   // [R6]
   assign ev_set[10:8]           = 3'h0;
   assign ev_set[EV_FIFO_EMPTY]  = 1'b0;
   assign ev_set[EV_NAK_EFF]     = nak_ff && !stall_ff && !clr_nak_wr; // [R8]
   assign ev_set[5]              = 1'b0;
   assign ev_set[EV_TOKEN_EMPTY] = token_in && fifo_empty;            // [R9]
   assign ev_set[EV_TIMEOUT]     = token_timeout;                     // [R10]
   assign ev_set[EV_BUS_ERR]     = ahb_error;                         // [R11]
   assign ev_set[EV_DISABLED]    = user_dis;                          // [R20]
   assign ev_set[EV_DONE]        = xfer_end;                          // [R12]

   wire [13:0]  ev_clr = wr_ev ? (bus.wdata[13:0] & EV_WRITABLE) : 14'h0000; // [R13]
   wire [13:0]  ev_view = {ev_ff[13:8], fifo_empty, ev_ff[6:0]};      // [R7]
   // Drop flag is excluded from the interrupt.
   wire [13:0]  ev_irq_mask = EV_WRITABLE & ~(14'h0001 << EV_DROP);   // [R6]
   wire         nxt_irq = |(ev_view & ev_irq_mask & ~(14'h0001 << EV_FIFO_EMPTY));

   // Read data selection.
   wire [31:0]  rd_sel =
      (bus.addr == OFS_EP0_CONTROL) ? {enable_ff, 13'h0000, nak_ff, 1'b0,
                                       1'b1, 13'h0000, mps_ff} :      // [R1] [R2]
      (bus.addr == OFS_EP0_EVENTS)  ? {18'h00000, ev_view} :
      (bus.addr == OFS_EP0_LENGTH)  ? {11'h000, pkt_ff, 12'h000, size_ff} :
      (bus.addr == OFS_EP0_DMA)     ? dma_ff :
      (bus.addr == OFS_EP0_FREE)    ? {16'h0000, free_ff} :           // [R19]
      32'h00000000;

   // Control register: enable, NAK, STALL and packet size code.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         enable_ff      <= 1'b0;
         nak_ff         <= 1'b0;
         stall_ff       <= 1'b0;
         mps_ff         <= MPS_64;
         disable_req_ff <= 1'b0;
      end else begin
         if (xfer_end || user_dis) begin
            enable_ff <= 1'b0;                                        // [R20]
         end else if (wr_ctl && bus.wdata[CTL_ENABLE]) begin
            enable_ff <= 1'b1;
         end
         disable_req_ff <= user_dis ? 1'b0 :
                           (wr_ctl && bus.wdata[CTL_DISABLE] && enable_ff) | disable_req_ff;
         if (wr_ctl && bus.wdata[CTL_SET_NAK]) begin
            nak_ff <= 1'b1;
         end else if (wr_ctl && bus.wdata[CTL_CLR_NAK]) begin
            nak_ff <= 1'b0;                                           // [R8]
         end
         if (setup_rcvd) begin
            stall_ff <= 1'b0;
         end else if (wr_ctl && bus.wdata[CTL_STALL]) begin
            stall_ff <= 1'b1;
         end
         if (wr_ctl) begin
            mps_ff <= bus.wdata[1:0];                                 // [R2]
         end
      end
   end

   // Event flags; NAK-effective also drops on a clear-NAK write.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ev_ff <= 14'h0000;
      end else begin
         ev_ff <= (ev_ff & ~ev_clr
                   & ~((wr_ctl && bus.wdata[CTL_CLR_NAK]) ? 14'h0040 : 14'h0000))
                  | ev_set;                                           // [R4] [R13]
      end
   end

   // Transfer length counters; software writes only while disabled.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pkt_ff  <= 2'h0;
         size_ff <= 7'h00;
      end else begin
         if (wr_len && !enable_ff) begin                              // [R16]
            pkt_ff  <= bus.wdata[LEN_PKT_HI:LEN_PKT_LO];
            size_ff <= bus.wdata[LEN_SIZE_HI:0];
         end else if (enable_ff) begin
            if (pkt_from_fifo && pkt_ff != 2'h0) begin
               pkt_ff <= pkt_ff - 2'h1;                               // [R14]
            end
            if (pkt_to_fifo) begin
               size_ff <= (pkt_bytes >= size_ff) ? 7'h00 : size_ff - pkt_bytes; // [R15]
            end
         end
      end
   end

   // DMA pointer, free space and SETUP slot tracking.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dma_ff       <= 32'h00000000;
         free_ff      <= FREE_RESET;                                  // [R19]
         setup_run_ff <= 2'h0;
         slot_ff      <= 3'h0;
      end else begin
         if (wr_dma) begin
            dma_ff <= {bus.wdata[31:2], 2'h0};                        // [R17]
         end else if (ahb_beat && !ahb_error) begin
            dma_ff <= dma_ff + DMA_STEP;                              // [R11] [R17]
         end
         free_ff <= fifo_free_in;
         if (setup_rcvd) begin
            setup_run_ff <= (setup_run_ff == 2'h2) ? 2'h0 : setup_run_ff + 2'h1; // [R18]
            slot_ff      <= {1'b0, setup_run_ff};
         end else if (pkt_to_fifo || pkt_from_fifo) begin
            setup_run_ff <= 2'h0;
         end
      end
   end

   // Bus answer and outputs.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_ff  <= 32'h00000000;
         rvalid_ff <= 1'b0;
         irq_ff    <= 1'b0;
      end else begin
         rdata_ff  <= rd ? rd_sel : 32'h00000000;
         rvalid_ff <= rd;
         irq_ff    <= nxt_irq;                                        // [R4]
      end
   end

   assign bus.rdata       = rdata_ff;
   assign bus.rvalid      = rvalid_ff;
   assign ep_enabled      = enable_ff;
   assign ep_nak          = nak_ff;
   assign ep_stall        = stall_ff;
   assign setup_slot      = slot_ff;
   assign ep_irq          = irq_ff;
   assign all_ep_summary  = irq_ff;
   assign core_in_summary = irq_ff;
endmodule

// ### ep_status_if.sv
`timescale 1ns/1ps
interface ep_status_if (
   input wire logic mclk
);
   import ep_status_pkg::*;
   op_t         op;
   logic [19:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        rvalid;
   modport device (
      input  op,
      input  addr,
      input  wdata,
      output rdata,
      output rvalid
   );
   modport ctrl (
      output op,
      output addr,
      output wdata,
      input  rdata,
      input  rvalid
   );
endinterface

// ### ep_status_pkg.sv
package ep_status_pkg;
   // Register offsets (byte addresses) of the endpoint 0 IN status block.
   localparam logic [19:0] OFS_EP0_CONTROL = 20'h3C900;
   localparam logic [19:0] OFS_EP0_EVENTS  = 20'h3C908;
   localparam logic [19:0] OFS_EP0_LENGTH  = 20'h3C910;
   localparam logic [19:0] OFS_EP0_DMA     = 20'h3C914;
   localparam logic [19:0] OFS_EP0_FREE    = 20'h3C918;
   localparam logic [19:0] OFS_EPN_CONTROL = 20'h3C920;
   // Controller-side register offsets.
   localparam logic [3:0]  HOFS_CMD        = 4'h0;
   localparam logic [3:0]  HOFS_ADDR       = 4'h1;
   localparam logic [3:0]  HOFS_WDATA      = 4'h2;
   localparam logic [3:0]  HOFS_RDATA      = 4'h3;
   localparam logic [3:0]  HOFS_STATUS     = 4'h4;
   // Control register field positions.
   localparam int          CTL_ENABLE      = 31;
   localparam int          CTL_DISABLE     = 30;
   localparam int          CTL_SET_NAK     = 27;
   localparam int          CTL_CLR_NAK     = 26;
   localparam int          CTL_STALL       = 21;
   localparam int          CTL_NAK_STS     = 17;
   localparam int          CTL_ACTIVE      = 15;
   // Event flag positions.
   localparam int          EV_NAK          = 13;
   localparam int          EV_BABBLE       = 12;
   localparam int          EV_DROP         = 11;
   localparam int          EV_FIFO_EMPTY   = 7;
   localparam int          EV_NAK_EFF      = 6;
   localparam int          EV_TOKEN_EMPTY  = 4;
   localparam int          EV_TIMEOUT      = 3;
   localparam int          EV_BUS_ERR      = 2;
   localparam int          EV_DISABLED     = 1;
   localparam int          EV_DONE         = 0;
   // Transfer length fields.
   localparam int          LEN_PKT_LO      = 19;
   localparam int          LEN_PKT_HI      = 20;
   localparam int          LEN_SIZE_HI     = 6;
   localparam logic [15:0] FREE_RESET      = 16'h0200;
   localparam logic [15:0] FREE_HALF       = 16'h0100;
   localparam logic [1:0]  MPS_64          = 2'h0;
   localparam logic [13:0] EV_WRITABLE     = 14'h385F;
   localparam logic [31:0] DMA_STEP        = 32'h00000004;
   // Bus transaction kinds carried on the shared interface.
   typedef enum logic [1:0] {
      OP_IDLE  = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ  = 2'h3
   } op_t;
endpackage

// ### ep_status_properties.sv
`timescale 1ns/1ps
// Checks on the shared bus between the controller and the endpoint status device.
module ep_status_properties (
   input wire logic               mclk,
   input wire logic               nrst,
   input wire ep_status_pkg::op_t op,
   input wire logic [19:0]        addr,
   input wire logic [31:0]        wdata,
   input wire logic [31:0]        rdata,
   input wire logic               rvalid
);
   import ep_status_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // A read request aimed at one register.
   sequence rd_at(logic [19:0] a);
      op == OP_READ && addr == a;
   endsequence
   // The answer to a read, valid in the following cycle only.
   sequence answer;
      rvalid;
   endsequence
   AST_RVALID_AFTER_READ: assert property (op == OP_READ |=> answer)
      else $error("read answer missing");
   AST_NO_STRAY_RVALID: assert property (rvalid |-> $past(op) == OP_READ)
      else $error("answer without a read");
   AST_RDATA_QUIET: assert property (!rvalid |-> rdata == 32'h00000000)
      else $error("read data outside the answer cycle");
   AST_EP0_ACTIVE: assert property (rd_at(OFS_EP0_CONTROL) |=> answer ##0 rdata[15])
      else $error("endpoint 0 active flag low");
   AST_EVENT_SPARE: assert property (rd_at(OFS_EP0_EVENTS) |=>
      rdata[31:14] == 18'h00000 && rdata[10:8] == 3'h0 && !rdata[5])
      else $error("spare event bits set");
   AST_LENGTH_SPARE: assert property (rd_at(OFS_EP0_LENGTH) |=>
      rdata[31:21] == 11'h000 && rdata[18:7] == 12'h000)
      else $error("spare length bits set");
   AST_DMA_ALIGNED: assert property (rd_at(OFS_EP0_DMA) |=> rdata[1:0] == 2'h0)
      else $error("pointer not word aligned");
   AST_FREE_WIDTH: assert property (rd_at(OFS_EP0_FREE) |=> rdata[31:16] == 16'h0000)
      else $error("free space above 16 bits");
endmodule

// ### usb_device_in_endpoint_status_tb.sv
`timescale 1ns/1ps
module usb_device_in_endpoint_status_tb;
   import ep_status_pkg::*;
   logic        mclk, nrst, sw_wr, sw_rd, half_empty_level, ahb_side_done;
   logic [3:0]  sw_addr;
   logic [31:0] sw_wdata, sw_rdata, q;
   logic [10:0] pl;
   logic [6:0]  pkt_bytes;
   logic [2:0]  setup_slot;
   logic [15:0] fifo_free_in;
   logic        ep_enabled, ep_nak, ep_stall, ep_irq, all_ep_summary, core_in_summary;
   int          err_total, tests_run, cyc, k;
   int          bits[6] = '{13, 13, 11, 12, 4, 3};
   ep_status_if bus_if (.mclk(mclk));
   ep_status_device ep_status_device_i (.mclk(mclk), .nrst(nrst), .bus(bus_if),
      .nak_sent(pl[0]), .iso_zero_len(pl[1]), .iso_out_dropped(pl[2]), .babble_seen(pl[3]),
      .token_in(pl[4]), .token_timeout(pl[5]), .ahb_beat(pl[6]), .ahb_error(pl[7]),
      .pkt_to_fifo(pl[8]), .pkt_bytes(pkt_bytes), .pkt_from_fifo(pl[9]),
      .setup_rcvd(pl[10]), .half_empty_level(half_empty_level),
      .ahb_side_done(ahb_side_done), .fifo_free_in(fifo_free_in), .ep_enabled(ep_enabled),
      .ep_nak(ep_nak), .ep_stall(ep_stall), .setup_slot(setup_slot), .ep_irq(ep_irq),
      .all_ep_summary(all_ep_summary), .core_in_summary(core_in_summary));
   ep_status_ctrl ep_status_ctrl_i (.mclk(mclk), .nrst(nrst), .bus(bus_if),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata));
   ep_status_properties ep_status_properties_i (.mclk(mclk), .nrst(nrst), .op(bus_if.op),
      .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
   // Clock source.
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Cuts a hung run short.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results();
      end
   end
   // Prints the counts and the verdict, then stops.
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask
   // Software port write and read; read data stand one cycle after the strobe.
   task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      sw_wr <= 1'b1;
      sw_addr <= a;
      sw_wdata <= d;
      @(posedge mclk);
      sw_wr <= 1'b0;
   endtask
   task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      sw_rd <= 1'b1;
      sw_addr <= a;
      @(posedge mclk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask
   // One device access through the controller, waiting on busy under a bound.
   task automatic dev(input logic rd, input logic [19:0] a, input logic [31:0] d);
      logic [31:0] s;
      int i;
      sw_write(HOFS_ADDR, {12'h000, a});
      sw_write(HOFS_WDATA, d);
      sw_write(HOFS_CMD, rd ? 32'h00000002 : 32'h00000001);
      s = 32'h00000001;
      for (i = 0; i < 8 && s[0] !== 1'b0; i++) sw_read(HOFS_STATUS, s);
      chk(s, 32'h00000000);
      sw_read(HOFS_RDATA, q);
   endtask
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      dev(1'b0, a, d);
   endtask
   task automatic rc(input logic [19:0] a, input logic [31:0] exp);
      dev(1'b1, a, 32'h00000000);
      chk(q, exp);
   endtask
   // One-cycle pulse on the selected event inputs.
   task automatic pulse(input logic [10:0] m);
      @(posedge mclk);
      pl <= m;
      @(posedge mclk);
      pl <= 11'h000;
   endtask
   // Main sequence.
   initial begin
      {nrst, sw_wr, sw_rd, half_empty_level, ahb_side_done} = 5'h00;
      {sw_addr, sw_wdata, pl, pkt_bytes} = '0;
      fifo_free_in = 16'h0200;
      repeat (5) @(posedge mclk);
      nrst <= 1'b1;
      rc(OFS_EP0_CONTROL, 32'h00008000);
      rc(OFS_EP0_EVENTS, 32'h00000080);
      rc(OFS_EP0_LENGTH, 32'h00000000);
      wr(OFS_EP0_FREE, 32'h00001234);
      rc(OFS_EP0_FREE, 32'h00000200);
      rc(20'h3C904, 32'h00000000);
      $display("test reset and map done");
      for (k = 0; k < 6; k++) begin
         pulse(11'(1 << k));
         wr(OFS_EP0_EVENTS, 32'h00000000);
         chk({30'h0, all_ep_summary, core_in_summary}, {30'h0, {2{k != 2}}});
         rc(OFS_EP0_EVENTS, 32'h00000080 | (32'h1 << bits[k]));
         chk({31'h0, ep_irq}, {31'h0, k != 2});
         wr(OFS_EP0_EVENTS, 32'h1 << bits[k]);
         rc(OFS_EP0_EVENTS, 32'h00000080);
         chk({30'h0, all_ep_summary, core_in_summary}, 32'h0);
      end
      $display("test event flags done");
      fifo_free_in <= 16'h0100;
      rc(OFS_EP0_EVENTS, 32'h00000000);
      half_empty_level <= 1'b1;
      rc(OFS_EP0_EVENTS, 32'h00000080);
      rc(OFS_EP0_FREE, 32'h00000100);
      fifo_free_in <= 16'h0200;
      $display("test fifo level done");
      wr(OFS_EP0_DMA, 32'h00001003);
      rc(OFS_EP0_DMA, 32'h00001000);
      pulse(11'h040);
      pulse(11'h040);
      pulse(11'h0C0);
      rc(OFS_EP0_DMA, 32'h00001008);
      rc(OFS_EP0_EVENTS, 32'h00000084);
      wr(OFS_EP0_EVENTS, 32'h00000004);
      $display("test dma pointer done");
      wr(OFS_EP0_LENGTH, 32'h00100064);
      wr(OFS_EP0_CONTROL, 32'h80000000);
      wr(OFS_EP0_LENGTH, 32'h00000000);
      pkt_bytes <= 7'd64;
      pulse(11'h100);
      pulse(11'h200);
      rc(OFS_EP0_LENGTH, 32'h00080024);
      pkt_bytes <= 7'd36;
      pulse(11'h100);
      pulse(11'h200);
      rc(OFS_EP0_LENGTH, 32'h00000000);
      rc(OFS_EP0_EVENTS, 32'h00000080);
      ahb_side_done <= 1'b1;
      rc(OFS_EP0_EVENTS, 32'h00000081);
      rc(OFS_EP0_CONTROL, 32'h00008000);
      ahb_side_done <= 1'b0;
      wr(OFS_EP0_EVENTS, 32'h00000001);
      $display("test transfer done");
      wr(OFS_EP0_CONTROL, 32'h08000002);
      rc(OFS_EP0_CONTROL, 32'h00028002);
      chk({31'h0, ep_nak}, 32'h1);
      rc(OFS_EP0_EVENTS, 32'h000000C0);
      wr(OFS_EP0_CONTROL, 32'h04000002);
      rc(OFS_EP0_EVENTS, 32'h00000080);
      wr(OFS_EP0_CONTROL, 32'h08200002);
      rc(OFS_EP0_EVENTS, 32'h00000080);
      pulse(11'h400);
      rc(OFS_EP0_EVENTS, 32'h000000C0);
      chk({31'h0, ep_stall}, 32'h0);
      chk({29'h0, setup_slot}, 32'h0);
      wr(OFS_EP0_CONTROL, 32'h04000000);
      wr(OFS_EP0_EVENTS, 32'h00000040);
      pulse(11'h400);
      #1 chk({29'h0, setup_slot}, 32'h1);
      pulse(11'h400);
      #1 chk({29'h0, setup_slot}, 32'h2);
      pulse(11'h400);
      #1 chk({29'h0, setup_slot}, 32'h0);
      $display("test nak done");
      wr(OFS_EP0_CONTROL, 32'h80000000);
      wr(OFS_EP0_CONTROL, 32'h40000000);
      rc(OFS_EP0_EVENTS, 32'h00000082);
      chk({31'h0, ep_enabled}, 32'h0);
      $display("test disable done");
      results();
   end
endmodule
